// ---- core/adfmt_pkg.sv ----
// Purpose: constants and types for the output data-format control block
// Assumes: 16-bit converter words, 4-wire serial configuration port
package adfmt_pkg;
	localparam int DATA_W = 16;
	localparam int FRAME_BITS = 16;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [6:0] ADDR_FORMAT = 7'h04;
	localparam logic [7:0] FORMAT_RESET = 8'h00;
	localparam logic [7:0] FORMAT_WMASK = 8'h3F;
	localparam int SRST_BIT = 7;
	localparam int PAT_LSB = 3;
	localparam int ALT_INV_BIT = 2;
	localparam int SCRAMBLE_BIT = 1;
	localparam int TWOS_BIT = 0;
	localparam logic [2:0] PAT_ZERO = 3'h1;
	localparam logic [2:0] PAT_ONES = 3'h3;
	localparam logic [2:0] PAT_CHECK = 3'h5;
	localparam logic [2:0] PAT_ALT = 3'h7;
	localparam logic [15:0] CHECK_A = 16'h5555;
	localparam logic [15:0] CHECK_B = 16'hAAAA;
	localparam logic [15:0] ALT_INV_MASK = 16'hAAAA;

	typedef struct packed {
		logic [2:0] pattern;
		logic alt_invert;
		logic scramble;
		logic twos;
	} adfmt_cfg_t;
endpackage : adfmt_pkg

// ---- core/adfmt_buf2.sv ----
// Purpose: two-entry valid/ready buffer for output words
// Assumes: single clock, active-low reset already synchronised
// Notes: full when two words held
`timescale 1ns/10ps
`default_nettype none
module adfmt_buf2 #(
	parameter int W = 16
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic in_valid, // word offered
	output logic in_ready, // room available
	input wire logic [W-1:0] in_data, // word in
	output logic out_valid, // word held
	input wire logic out_ready, // receiver takes
	output logic [W-1:0] out_data // oldest word
);
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic rd_r, rd_nxt;
	logic wr_r, wr_nxt;
	logic push, pop;
	logic in_ready_r, in_ready_nxt;

	// room flag kept in a flop so the top output comes straight from a register
	assign in_ready = in_ready_r;
	assign out_valid = (cnt_r != 2'd0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_nxt = mem_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_data;
			wr_nxt = ~wr_r;
		end
		if (pop) begin
			rd_nxt = ~rd_r;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'd1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'd1;
		end
		in_ready_nxt = (cnt_nxt != 2'h2);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'd0;
			in_ready_r <= 1'b0;
		end else begin
			in_ready_r <= in_ready_nxt;
			mem_r <= mem_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : adfmt_buf2
`default_nettype wire

// ---- core/adfmt_top.sv ----
// Purpose: serial-programmed data-format register and output word formatter
// Assumes: serial pins sampled by SYS_CLK, well above serial clock rate
// Notes: randomizer xors bits 15..1 with bit 0; alternate polarity inverts odd bits
`timescale 1ns/10ps
`default_nettype none
module adfmt_top #(
	parameter int DATA_W = adfmt_pkg::DATA_W
) (
	input wire logic SYS_CLK, // 40 MHz clock
	input wire logic RESETN, // async reset, active low
	input wire logic CS_N, // serial select, active low
	input wire logic SCK, // serial clock
	input wire logic SDI, // serial data in
	output logic SDO_OUT, // serial out level, always 0
	output logic SDO_OE_N, // low pulls serial out low
	input wire logic SAMPLE_VALID, // converter word offered
	input wire logic [DATA_W-1:0] SAMPLE_DATA, // converter word, offset binary
	output logic SAMPLE_READY, // formatter accepts word
	output logic OUT_VALID, // formatted word valid
	input wire logic OUT_READY, // capture logic takes word
	output logic [DATA_W-1:0] OUT_DATA, // formatted word
	output logic [7:0] FORMAT_REG // data-format register contents
);
	// ----------------------------------------------------------------
	// reset and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [1:0] cs_s_r, sck_s_r, sdi_s_r;
	logic sck_d_r;

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cs_s_r <= 2'b11;
			sck_s_r <= 2'b00;
			sdi_s_r <= 2'b00;
			sck_d_r <= 1'b0;
		end else begin
			cs_s_r <= {cs_s_r[0], CS_N};
			sck_s_r <= {sck_s_r[0], SCK};
			sdi_s_r <= {sdi_s_r[0], SDI};
			sck_d_r <= sck_s_r[1];
		end
	end

	// ----------------------------------------------------------------
	// serial frame engine
	// ----------------------------------------------------------------
	logic sel, rise, fall;
	logic [4:0] bit_cnt_r, bit_cnt_nxt;
	logic [15:0] shift_r, shift_nxt;
	logic [7:0] rd_sh_r, rd_sh_nxt;
	logic sdo_oe_n_r, sdo_oe_n_nxt;
	logic [7:0] fmt_r, fmt_nxt;
	logic srst_r, srst_nxt;
	logic [7:0] rd_val;

	assign sel = !cs_s_r[1];
	assign rise = sck_s_r[1] && !sck_d_r;
	assign fall = !sck_s_r[1] && sck_d_r;

	always_comb begin
		// readback value; the address completes with the incoming bit
		case ({shift_r[5:0], sdi_s_r[1]})
			adfmt_pkg::ADDR_FORMAT: rd_val = fmt_r;
			default: rd_val = 8'h00;
		endcase
	end

	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		rd_sh_nxt = rd_sh_r;
		sdo_oe_n_nxt = sdo_oe_n_r;
		fmt_nxt = fmt_r;
		srst_nxt = 1'b0;
		if (srst_r) begin
			fmt_nxt = adfmt_pkg::FORMAT_RESET;
		end
		if (!sel) begin
			bit_cnt_nxt = 5'd0;
			sdo_oe_n_nxt = 1'b1;
			// ones keep the pin released on write frames
			rd_sh_nxt = 8'hFF;
		end else begin
			if (rise && bit_cnt_r < 5'(adfmt_pkg::FRAME_BITS)) begin
				shift_nxt = {shift_r[14:0], sdi_s_r[1]};
				bit_cnt_nxt = bit_cnt_r + 5'd1;
				if (bit_cnt_r == 5'd7 && shift_r[6]) begin
					rd_sh_nxt = rd_val;
				end
				if (bit_cnt_r == 5'd15 && !shift_r[14]) begin
					if (shift_r[13:7] == adfmt_pkg::ADDR_FORMAT) begin
						fmt_nxt = {shift_r[6:0], sdi_s_r[1]} & adfmt_pkg::FORMAT_WMASK;
					end
					if (shift_r[13:7] == adfmt_pkg::ADDR_RESET && shift_r[6]) begin
						srst_nxt = 1'b1;
					end
				end
			end
			if (fall && bit_cnt_r >= 5'd8 && bit_cnt_r < 5'd16) begin
				sdo_oe_n_nxt = rd_sh_r[7];
				rd_sh_nxt = {rd_sh_r[6:0], 1'b1};
			end else if (fall && bit_cnt_r >= 5'd16) begin
				sdo_oe_n_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_r <= 5'd0;
			shift_r <= 16'h0000;
			rd_sh_r <= 8'hFF;
			sdo_oe_n_r <= 1'b1;
			fmt_r <= adfmt_pkg::FORMAT_RESET;
			srst_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			rd_sh_r <= rd_sh_nxt;
			sdo_oe_n_r <= sdo_oe_n_nxt;
			fmt_r <= fmt_nxt;
			srst_r <= srst_nxt;
		end
	end

	// ----------------------------------------------------------------
	// output word formatter
	// ----------------------------------------------------------------
	adfmt_pkg::adfmt_cfg_t cfg;
	logic [DATA_W-1:0] fw;
	logic [DATA_W-1:0] pat_full;
	logic toggle_r, toggle_nxt;
	logic in_ready;
	logic push;

	assign cfg = adfmt_pkg::adfmt_cfg_t'(fmt_r[5:0]);
	assign pat_full = {DATA_W{1'b1}};
	assign push = SAMPLE_VALID && in_ready;

	always_comb begin
		fw = SAMPLE_DATA;
		if (cfg.twos) begin
			fw[DATA_W-1] = ~fw[DATA_W-1];
		end
		if (cfg.scramble) begin
			fw[DATA_W-1:1] = fw[DATA_W-1:1] ^ {(DATA_W-1){fw[0]}};
		end
		if (cfg.alt_invert) begin
			fw = fw ^ adfmt_pkg::ALT_INV_MASK[DATA_W-1:0];
		end
		case (cfg.pattern)
			adfmt_pkg::PAT_ZERO: fw = '0;
			adfmt_pkg::PAT_ONES: fw = pat_full;
			adfmt_pkg::PAT_CHECK: fw = toggle_r ? adfmt_pkg::CHECK_B[DATA_W-1:0]
				: adfmt_pkg::CHECK_A[DATA_W-1:0];
			adfmt_pkg::PAT_ALT: fw = toggle_r ? pat_full : '0;
			default: ;
		endcase
		toggle_nxt = push ? ~toggle_r : toggle_r;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			toggle_r <= 1'b0;
		end else begin
			toggle_r <= toggle_nxt;
		end
	end

	logic buf_valid;
	logic [DATA_W-1:0] buf_data;
	logic out_valid_r, out_valid_nxt;
	logic [DATA_W-1:0] out_data_r, out_data_nxt;
	logic buf_take;

	adfmt_buf2 #(.W(DATA_W)) u_buf (
		.clk(SYS_CLK),
		.rst_n(rst_n),
		.in_valid(SAMPLE_VALID),
		.in_ready(in_ready),
		.in_data(fw),
		.out_valid(buf_valid),
		.out_ready(buf_take),
		.out_data(buf_data)
	);

	// output stage register, refilled when empty or taken
	assign buf_take = !out_valid_r || OUT_READY;

	always_comb begin
		out_valid_nxt = out_valid_r;
		out_data_nxt = out_data_r;
		if (buf_take) begin
			out_valid_nxt = buf_valid;
			out_data_nxt = buf_valid ? buf_data : out_data_r;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else begin
			out_valid_r <= out_valid_nxt;
			out_data_r <= out_data_nxt;
		end
	end

	assign SAMPLE_READY = in_ready;
	assign OUT_VALID = out_valid_r;
	assign OUT_DATA = out_data_r;
	assign FORMAT_REG = fmt_r;
	assign SDO_OUT = 1'b0;
	assign SDO_OE_N = sdo_oe_n_r;
endmodule : adfmt_top
`default_nettype wire

// ---- dv/adfmt_chk.sv ----
// Purpose: port checker for adfmt_top
// Assumes: one clock, RESETN active low
// Notes: bound after endmodule
`timescale 1ns/10ps
`default_nettype none
module adfmt_chk #(
	parameter int DATA_W = 16
) (
	input wire logic SYS_CLK, // clock
	input wire logic RESETN, // reset
	input wire logic CS_N, // select
	input wire logic SAMPLE_VALID, // offered
	input wire logic SAMPLE_READY, // room
	input wire logic OUT_VALID, // word valid
	input wire logic OUT_READY, // word taken
	input wire logic [DATA_W-1:0] OUT_DATA, // word
	input wire logic SDO_OUT, // serial level
	input wire logic SDO_OE_N, // serial enable
	input wire logic [7:0] FORMAT_REG // register
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	property p_hi; FORMAT_REG[7:6] == 2'b00; endproperty
	a_hi: assert property (p_hi) else $error("bits 7:6 set");
	property p_hold; OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA); endproperty
	a_hold: assert property (p_hold) else $error("word not held");
	property p_idle; CS_N [*5] |-> SDO_OE_N; endproperty
	a_idle: assert property (p_idle) else $error("serial out driven idle");
	property p_low; SDO_OUT == 1'b0; endproperty
	a_low: assert property (p_low) else $error("serial level high");
	property p_quiet; CS_N [*8] |=> $stable(FORMAT_REG); endproperty
	a_quiet: assert property (p_quiet) else $error("register moved idle");
	property p_full; !SAMPLE_READY && $past(SAMPLE_READY) |-> OUT_VALID; endproperty
	a_full: assert property (p_full) else $error("refused while empty");
	property p_lat; SAMPLE_VALID && SAMPLE_READY && !OUT_VALID |-> ##[1:3] OUT_VALID; endproperty
	a_lat: assert property (p_lat) else $error("word late");
	property p_rst; $rose(RESETN) |-> FORMAT_REG == 8'h00 && SDO_OE_N && !OUT_VALID; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : adfmt_chk
bind adfmt_top adfmt_chk #(.DATA_W(DATA_W)) adfmt_chk_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
	.CS_N(CS_N), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
	.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .SDO_OUT(SDO_OUT),
	.SDO_OE_N(SDO_OE_N), .FORMAT_REG(FORMAT_REG));
`default_nettype wire

// ---- dv/adfmt_sink.sv ----
// Purpose: capture logic model on the word stream
// Assumes: ready changes just after the edge
// Notes: stall holds ready low
`timescale 1ns/10ps
`default_nettype none
module adfmt_sink (
	input wire logic clk, // clock
	input wire logic valid, // word offered
	input wire logic [15:0] data, // word
	input wire logic stall, // hold off
	output logic ready // taking
);
	logic [15:0] got [$];
	initial ready = 1'b0;
	always @(posedge clk) begin
		if (valid && ready) got.push_back(data);
		ready <= #1 !stall;
	end
endmodule : adfmt_sink
`default_nettype wire

// ---- dv/adfmt_bench.sv ----
// Purpose: self-checking bench for adfmt_top
// Assumes: serial frames of 16 bits, 8 cycles per bit
// Notes: words checked through adfmt_sink
`timescale 1ns/10ps
`default_nettype none
module adfmt_bench;
	logic SYS_CLK = 0, RESETN = 0, CS_N = 1, SCK = 0, SDI = 0, SAMPLE_VALID = 0, stall = 0;
	logic [15:0] SAMPLE_DATA = 16'h0000;
	logic SDO_OUT, SDO_OE_N, SAMPLE_READY, OUT_VALID, OUT_READY;
	logic [15:0] OUT_DATA, w0, w1, p;
	logic [7:0] FORMAT_REG, rd;
	logic [7:0] cfgs [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07, 8'h08, 8'h18, 8'h10, 8'h28, 8'h38};
	int bad_count = 0, check_count = 0, cyc = 0;
	always #12.5 SYS_CLK = ~SYS_CLK;
	adfmt_top adfmt_top_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CS_N(CS_N), .SCK(SCK), .SDI(SDI),
		.SDO_OUT(SDO_OUT), .SDO_OE_N(SDO_OE_N), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_READY(SAMPLE_READY), .OUT_VALID(OUT_VALID),
		.OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .FORMAT_REG(FORMAT_REG));
	adfmt_sink adfmt_sink_i (.clk(SYS_CLK), .valid(OUT_VALID), .data(OUT_DATA), .stall(stall),
		.ready(OUT_READY));
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : tick
	// serial pins sampled through the open-drain pull-up
	task automatic frame(logic rw, logic [6:0] a, logic [7:0] d);
		logic [15:0] w;
		w = {rw, a, d};
		CS_N = 0;
		for (int i = 0; i < 16; i++) begin
			SCK = 0;
			SDI = w[15-i];
			tick(4);
			if (i > 7) rd[15-i] = SDO_OE_N ? 1'b1 : SDO_OUT;
			SCK = 1;
			tick(4);
		end
		SCK = 0;
		tick(4);
		CS_N = 1;
		tick(8);
	endtask : frame
	task automatic put(logic [15:0] w);
		SAMPLE_DATA = w;
		SAMPLE_VALID = 1;
		// ready is settled here; the word is taken at the next edge
		while (SAMPLE_READY !== 1'b1) tick(1);
		tick(1);
	endtask : put
	task automatic get(output logic [15:0] w);
		int k;
		k = 0;
		while (adfmt_sink_i.got.size() == 0 && k < 200) begin
			tick(1);
			k++;
		end
		w = adfmt_sink_i.got.size() != 0 ? adfmt_sink_i.got.pop_front() : 16'hxxxx;
	endtask : get
	function automatic logic [15:0] fmt(logic [7:0] f, logic [15:0] s);
		logic [15:0] v;
		v = s ^ {f[0], 15'h0000};
		if (f[1]) v = v ^ {{15{v[0]}}, 1'b0};
		if (f[2]) v = v ^ 16'hAAAA;
		if (f[5:3] == 3'h1) v = 16'h0000;
		if (f[5:3] == 3'h3) v = 16'hFFFF;
		return v;
	endfunction : fmt
	initial begin
		tick(6);
		RESETN = 1;
		tick(4);
		frame(0, 7'h00, 8'h80);
		chk("srst", 8'h00, FORMAT_REG);
		frame(0, 7'h04, 8'hFF);
		chk("mask", 8'h3F, FORMAT_REG);
		frame(1, 7'h04, 8'hC3);
		chk("readback", 8'h3F, rd);
		chk("unchanged", 8'h3F, FORMAT_REG);
		frame(1, 7'h05, 8'h00);
		chk("other", 8'h00, rd);
		frame(0, 7'h00, 8'h80);
		chk("clear", 8'h00, FORMAT_REG);
		$display("test registers done");
		stall = 1;
		put(16'h1111);
		put(16'h2222);
		put(16'h3333);
		SAMPLE_VALID = 0;
		tick(6);
		chk("refuse", 1'b0, SAMPLE_READY);
		stall = 0;
		for (int i = 1; i < 4; i++) begin
			get(w0);
			chk("order", 16'h1111 * i, w0);
		end
		$display("test stall done");
		foreach (cfgs[j]) begin
			frame(0, 7'h04, cfgs[j]);
			chk("format", cfgs[j], FORMAT_REG);
			put(16'h1235);
			put(16'h8000);
			SAMPLE_VALID = 0;
			get(w0);
			get(w1);
			p = cfgs[j][4] ? 16'h0000 : 16'h5555;
			if (cfgs[j][5:3] == 3'h5 || cfgs[j][5:3] == 3'h7) begin
				chk("pair", ~w0, w1);
				chk("pattern", 1'b1, w0 === p || w0 === ~p);
			end else begin
				chk("word0", fmt(cfgs[j], 16'h1235), w0);
				chk("word1", fmt(cfgs[j], 16'h8000), w1);
			end
		end
		$display("test formats done");
		summarize();
	end
endmodule : adfmt_bench
`default_nettype wire
